/* File: inc/sbce_pkg.sv */
// Purpose: Constants for the status blink code encoder.
// Assumes: 100 MHz system clock, synchronous active-low reset.
// Notes: Times are kept in milliseconds; cycle counts derive from them.
//
// Summary of operation
// - Blink is 200 ms on, 200 ms off.
// - Tens blinks, 750 ms gap, ones blinks.
// - No tens digit means ones only.
// - Digit value equals its blink count.
// - 2 s off, then repeat while active.
// - Largest active code wins.
// - Calibration code 1, empty pipe 2.
// - Memory faults map to 11, 12, 13.
// - Wiring board 21, flyback board 22.
// - Front end 24, coil 25, temperature 26.
// - Factory unlocked maps to 33, highest.
// - Screen-only faults never blink.
package sbce_pkg;

  // Number of condition flag inputs.
  localparam int NUM_COND = 11;

  // Bit positions of the condition flags.
  localparam int COND_CAL = 0;
  localparam int COND_EMPTY = 1;
  localparam int COND_NVM_CFG = 2;
  localparam int COND_NVM_RD = 3;
  localparam int COND_NVM_WR = 4;
  localparam int COND_WIRING = 5;
  localparam int COND_FLYBACK = 6;
  localparam int COND_AFE = 7;
  localparam int COND_COIL = 8;
  localparam int COND_TEMP = 9;
  localparam int COND_UNLOCK = 10;

  // Blink codes as tens and ones digits packed in one byte, indexed by flag position.
  typedef logic [7:0] sbce_code_t;
  localparam sbce_code_t CODE_TABLE [NUM_COND] = '{
    8'h01, 8'h02, 8'h11, 8'h12, 8'h13, 8'h21, 8'h22, 8'h24, 8'h25, 8'h26, 8'h33
  };

  // Time base.
  localparam int CLK_HZ = 100_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;

  // Phase durations in milliseconds.
  localparam int BLINK_ON_MS = 200;
  localparam int BLINK_OFF_MS = 200;
  localparam int DIGIT_GAP_MS = 750;
  localparam int REPEAT_GAP_MS = 2000;

  // Counter width for the millisecond counter.
  localparam int MS_W = 12;
  localparam logic [MS_W-1:0] MS_ZERO = 12'h000;

  // Phase lengths in milliseconds, sized for the counter.
  localparam logic [MS_W-1:0] ON_MS = MS_W'(BLINK_ON_MS);
  localparam logic [MS_W-1:0] OFF_MS = MS_W'(BLINK_OFF_MS);
  localparam logic [MS_W-1:0] GAP_MS = MS_W'(DIGIT_GAP_MS);
  localparam logic [MS_W-1:0] REP_MS = MS_W'(REPEAT_GAP_MS);

  // Sequencer states.
  typedef enum logic [2:0] {
    SBCE_IDLE,
    SBCE_ON,
    SBCE_OFF,
    SBCE_GAP,
    SBCE_REPEAT
  } sbce_state_t;

endpackage : sbce_pkg

/* File: verilog/sbce_ms_tick.sv */
// Purpose: Millisecond tick generator for the blink sequencer.
// Assumes: Clock rate as given in the package.
// Notes: Tick is a one-cycle pulse every CYC_PER_MS cycles.
`timescale 1ns/1ps
module sbce_ms_tick #(
  parameter int CYCLES = sbce_pkg::CYC_PER_MS
) (
  input wire logic clk,
  input wire logic resetn,
  output logic tick
);

  // Prescale counter; wide enough for any practical clock rate.
  logic [31:0] count;

  // Count up and wrap, pulsing tick on the wrap.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      count <= 32'h00000000;
      tick <= 1'b0;
    end else if (count == 32'(CYCLES - 1)) begin
      count <= 32'h00000000;
      tick <= 1'b1;
    end else begin
      count <= count + 32'h00000001;
      tick <= 1'b0;
    end
  end

endmodule : sbce_ms_tick

/* File: verilog/sbce_top.sv */
// Purpose: Encodes the highest active condition as a repeating LED blink code.
// Assumes: Condition flags are synchronous to clk and are levels.
// Notes: A pattern in progress always runs to completion before re-sampling.
`timescale 1ns/1ps
module sbce_top #(
  parameter int MS_CYCLES = sbce_pkg::CYC_PER_MS
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [sbce_pkg::NUM_COND-1:0] cond,
  output logic led,
  output logic [7:0] active_code
);

  ////////////////////////////////////////////////////////////////////////////
  // Time base.

  // One-cycle pulse per millisecond.
  logic ms_tick;

  sbce_ms_tick #(.CYCLES(MS_CYCLES)) u_tick (
    .clk(clk),
    .resetn(resetn),
    .tick(ms_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Priority selection.

  // Highest code among the active flags; zero when none is active.
  sbce_pkg::sbce_code_t best_code;

  // Codes rise with flag index, so the last active index gives the largest code.
  // Screen-only faults have no input here, so they can never blink.
  always_comb begin
    best_code = 8'h00;
    for (int i = 0; i < sbce_pkg::NUM_COND; i++) begin
      if (cond[i]) begin
        best_code = sbce_pkg::CODE_TABLE[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer.

  // Current phase of the pattern.
  sbce_pkg::sbce_state_t state;
  // Milliseconds remaining in the current phase.
  logic [sbce_pkg::MS_W-1:0] ms_left;
  // Blinks remaining in the current digit, including the one in progress.
  logic [3:0] blinks_left;
  // High while the tens digit is being shown.
  logic in_tens;
  // End of the current timed phase.
  logic phase_done;

  assign phase_done = ms_tick && (ms_left == sbce_pkg::MS_ZERO + 12'h001);

  // Phase sequencing; the code is latched only in idle and cleared when the repeat gap ends.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= sbce_pkg::SBCE_IDLE;
      ms_left <= sbce_pkg::MS_ZERO;
      blinks_left <= 4'h0;
      in_tens <= 1'b0;
      active_code <= 8'h00;
    end else begin
      case (state)
        sbce_pkg::SBCE_IDLE: begin
          // Sample at a repetition boundary only.
          if (best_code != 8'h00) begin
            active_code <= best_code;
            state <= sbce_pkg::SBCE_ON;
            ms_left <= sbce_pkg::ON_MS;
            // Start with tens if present, else ones.
            if (best_code[7:4] != 4'h0) begin
              in_tens <= 1'b1;
              blinks_left <= best_code[7:4];
            end else begin
              in_tens <= 1'b0;
              blinks_left <= best_code[3:0];
            end
          end
        end
        sbce_pkg::SBCE_ON: begin
          if (ms_tick) begin
            ms_left <= ms_left - 12'h001;
          end
          if (phase_done) begin
            state <= sbce_pkg::SBCE_OFF;
            ms_left <= sbce_pkg::OFF_MS;
          end
        end
        sbce_pkg::SBCE_OFF: begin
          if (ms_tick) begin
            ms_left <= ms_left - 12'h001;
          end
          if (phase_done) begin
            if (blinks_left != 4'h1) begin
              // More blinks in this digit.
              blinks_left <= blinks_left - 4'h1;
              state <= sbce_pkg::SBCE_ON;
              ms_left <= sbce_pkg::ON_MS;
            end else if (in_tens) begin
              state <= sbce_pkg::SBCE_GAP;
              ms_left <= sbce_pkg::GAP_MS;
            end else begin
              state <= sbce_pkg::SBCE_REPEAT;
              ms_left <= sbce_pkg::REP_MS;
            end
          end
        end
        sbce_pkg::SBCE_GAP: begin
          if (ms_tick) begin
            ms_left <= ms_left - 12'h001;
          end
          if (phase_done) begin
            // Ones digit follows; a code with zero ones skips to repeat gap.
            in_tens <= 1'b0;
            if (active_code[3:0] != 4'h0) begin
              blinks_left <= active_code[3:0];
              state <= sbce_pkg::SBCE_ON;
              ms_left <= sbce_pkg::ON_MS;
            end else begin
              state <= sbce_pkg::SBCE_REPEAT;
              ms_left <= sbce_pkg::REP_MS;
            end
          end
        end
        sbce_pkg::SBCE_REPEAT: begin
          if (ms_tick) begin
            ms_left <= ms_left - 12'h001;
          end
          if (phase_done) begin
            state <= sbce_pkg::SBCE_IDLE;
            active_code <= 8'h00;
          end
        end
        default: begin
          state <= sbce_pkg::SBCE_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // LED output.

  // Registered so the LED never glitches; it lags the state by one cycle.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      led <= 1'b0;
    end else begin
      led <= (state == sbce_pkg::SBCE_ON);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  // Reset leaves the LED dark.
  property p_reset_dark;
    @(posedge clk) !resetn |=> !led;
  endproperty
  a_reset_dark: assert property (p_reset_dark) else $error("LED lit after reset");

  // With nothing active in idle, the LED stays dark.
  property p_idle_dark;
    @(posedge clk) disable iff (!resetn) (state == sbce_pkg::SBCE_IDLE) |=> !led;
  endproperty
  a_idle_dark: assert property (p_idle_dark) else $error("LED lit while idle");

  // Code is latched only from idle and held until the repeat gap ends.
  property p_code_stable;
    @(posedge clk) disable iff (!resetn)
      (state != sbce_pkg::SBCE_IDLE && state != sbce_pkg::SBCE_REPEAT) |=> $stable(active_code) ||
      $past(state) == sbce_pkg::SBCE_IDLE;
  endproperty
  a_code_stable: assert property (p_code_stable) else $error("Code changed mid pattern");

  // With the unlock flag set, a sampled code is 33, the largest one.
  property p_pick_max;
    @(posedge clk) disable iff (!resetn)
      (state == sbce_pkg::SBCE_IDLE && cond[sbce_pkg::COND_UNLOCK]) |=> active_code == 8'h33;
  endproperty
  a_pick_max: assert property (p_pick_max) else $error("Unlock did not win");

  // Empty pipe with nothing above it selects code 2, whatever the calibration flag says.
  property p_empty_code;
    @(posedge clk) disable iff (!resetn)
      (state == sbce_pkg::SBCE_IDLE && cond[sbce_pkg::COND_EMPTY] &&
      cond[sbce_pkg::NUM_COND-1:sbce_pkg::COND_NVM_CFG] == 9'h000) |=> active_code == 8'h02;
  endproperty
  a_empty_code: assert property (p_empty_code) else $error("Empty pipe code wrong");

  // Tens phase always ends in the digit gap.
  property p_tens_gap;
    @(posedge clk) disable iff (!resetn)
      (state == sbce_pkg::SBCE_OFF && phase_done && blinks_left == 4'h1 && in_tens) |=>
      state == sbce_pkg::SBCE_GAP;
  endproperty
  a_tens_gap: assert property (p_tens_gap) else $error("No gap after tens");

  // Single-digit codes never enter the digit gap.
  property p_no_tens_gap;
    @(posedge clk) disable iff (!resetn)
      (state == sbce_pkg::SBCE_GAP) |-> active_code[7:4] != 4'h0;
  endproperty
  a_no_tens_gap: assert property (p_no_tens_gap) else $error("Gap without tens digit");

  // Each on phase starts with its full millisecond count loaded.
  property p_on_len;
    @(posedge clk) disable iff (!resetn)
      ($rose(state == sbce_pkg::SBCE_ON)) |-> ms_left == sbce_pkg::ON_MS;
  endproperty
  a_on_len: assert property (p_on_len) else $error("On phase length wrong");

  // Ones blink count never exceeds the ones digit value.
  property p_count;
    @(posedge clk) disable iff (!resetn)
      (state == sbce_pkg::SBCE_ON && !in_tens) |-> blinks_left <= active_code[3:0];
  endproperty
  a_count: assert property (p_count) else $error("Too many ones blinks");

  // Repeat gap is followed by idle resampling.
  property p_repeat;
    @(posedge clk) disable iff (!resetn)
      (state == sbce_pkg::SBCE_REPEAT && phase_done) |=> state == sbce_pkg::SBCE_IDLE;
  endproperty
  a_repeat: assert property (p_repeat) else $error("Repeat gap did not resample");

endmodule : sbce_top

/* File: verif/sbce_led_model.sv */
// Purpose: Status LED observer that decodes blink patterns into codes.
// Assumes: LED active high; MS gives clock cycles per millisecond.
// Notes: Runs are judged with a few cycles of slack for tick alignment.
`timescale 1ns/1ps
module sbce_led_model #(
  parameter int MS = 2
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic led,
  output logic [7:0] code,
  output logic code_valid,
  output logic fault
);
  int run; // Cycles since the LED last changed.
  int cnt; // Blinks counted in the current digit.
  logic [3:0] tens; // Tens digit once its separator was seen.
  logic prev; // LED level on the previous edge.
  logic seen; // A code was already decoded, so the repeat gap is timed.
  logic lit; // The LED has lit since reset, so an off run before a rise can be judged.

  // True when a run is within slack of a nominal length in milliseconds.
  function automatic bit near(input int n, input int ms);
    return (n >= ms * MS - 6) && (n <= ms * MS + 6);
  endfunction : near

  ////////////////////////////////////////////////////////////////////////////
  // Decoder: the LED is passive, so the model only watches and judges it.
  always @(posedge clk) begin
    code_valid <= 1'b0;
    if (!resetn) begin
      run = 0;
      cnt = 0;
      tens = 4'h0;
      seen = 1'b0;
      prev = 1'b0;
      lit = 1'b0;
      fault <= 1'b0;
      code <= 8'h00;
    end else if (led && !prev) begin
      // A long off run split digits or ended a code; the shortest sits inside a digit.
      // The first blink after reset follows no earlier blink, so its off run is not timed.
      if (!lit) begin
        lit = 1'b1;
      end else if (run < 500 * MS) begin
        if (!near(run, 200)) fault <= 1'b1;
      end else if (run < 1500 * MS) begin
        if (!near(run, 950)) fault <= 1'b1;
        tens = cnt[3:0];
        cnt = 0;
      end else if (seen && !near(run, 2201)) begin
        fault <= 1'b1;
      end
      run = 1;
    end else if (!led && prev) begin
      if (!near(run, 200)) fault <= 1'b1;
      cnt++;
      run = 1;
    end else begin
      run++;
      // Deep into the closing gap the code is complete.
      if (!led && run == 1500 * MS && cnt > 0) begin
        code <= {tens, cnt[3:0]};
        code_valid <= 1'b1;
        seen = 1'b1;
        tens = 4'h0;
        cnt = 0;
      end
    end
    prev = led;
  end
endmodule : sbce_led_model

/* File: verif/sbce_top_tb.sv */
// Purpose: Self-checking bench for the status blink code encoder.
// Assumes: Small MS_CYCLES keeps every pattern short.
// Notes: Each condition set after the first is applied mid-pattern, so patterns run back to back.
`timescale 1ns/1ps
module sbce_top_tb;
  localparam int MS = 2;
  // Expected blink code for each single condition flag.
  localparam logic [7:0] EXP [11] = '{8'h01, 8'h02, 8'h11, 8'h12, 8'h13, 8'h21, 8'h22, 8'h24, 8'h25, 8'h26, 8'h33};
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [10:0] cond = 11'h000;
  logic led;
  logic [7:0] active_code;
  logic [7:0] m_code;
  logic m_valid;
  logic m_fault;
  int mismatches = 0;
  int num_checks = 0;
  int seed = 91;
  logic [7:0] expq [$]; // Codes expected from the LED, oldest first.

  always #5 clk = ~clk;

  sbce_top #(.MS_CYCLES(MS)) i_sbce_top (.clk(clk), .resetn(resetn), .cond(cond), .led(led),
    .active_code(active_code));
  sbce_led_model #(.MS(MS)) i_sbce_led_model (.clk(clk), .resetn(resetn), .led(led), .code(m_code),
    .code_valid(m_valid), .fault(m_fault));

  ////////////////////////////////////////////////////////////////////////////
  // Compare, report and close.
  task check_code(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_code

  task summarize;
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  // Bounded wait until the shown code is zero or nonzero; a timeout is a failure.
  task wait_code(input bit nonzero);
    int i;
    i = 0;
    while (((active_code !== 8'h00) != nonzero) && i < 20000) begin
      @(posedge clk);
      #1;
      i++;
    end
    if (i >= 20000) begin
      mismatches++;
      summarize();
    end
  endtask : wait_code

  ////////////////////////////////////////////////////////////////////////////
  // Watcher: every decoded LED pattern consumes the oldest expectation.
  always @(posedge clk) begin
    if (m_valid === 1'b1) begin
      check_code(m_code, (expq.size() > 0) ? expq.pop_front() : 8'hFF);
      check_code({7'h00, m_fault}, 8'h00);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Driver: one flag per pass, with random lower-priority flags beside it.
  initial begin
    logic [10:0] r;
    int highs;
    repeat (8) begin
      @(posedge clk);
      #1;
      check_code(active_code, 8'h00);
      check_code({7'h00, led}, 8'h00);
    end
    resetn = 1'b1;
    for (int k = 0; k < 11; k++) begin
      r = 11'($random(seed));
      // Changed while the previous pattern still runs; it must not be cut short.
      cond = 11'(1 << k) | (r & 11'((1 << k) - 1));
      expq.push_back(EXP[k]);
      if (k > 0) wait_code(1'b0);
      wait_code(1'b1);
      check_code(active_code, EXP[k]);
      repeat (50) @(posedge clk);
      #1;
    end
    cond = 11'h000;
    wait_code(1'b0);
    // With nothing active the LED must stay dark.
    highs = 0;
    repeat (4500) begin
      @(posedge clk);
      #1;
      if (led !== 1'b0 || active_code !== 8'h00) highs++;
    end
    check_code({7'h00, highs != 0}, 8'h00);
    check_code(8'(expq.size()), 8'h00);
    summarize();
  end
endmodule : sbce_top_tb
